// *** hdl/chc_cache_hierarchy_control.v ***
// Summary of operation
// RULE1: Level-1 lines 64 bytes, level-2 256 bytes
// RULE2: Level-2 eviction flushes level-1 copies
// RULE3: Instruction-stream store invalidates instruction line
// RULE4: Instruction cache 64K, 2 ways, parity
// RULE5: Fetch bypass on recovery, disabled, uncacheable
// RULE6: Force-cacheable overrides fetch bypass only
// RULE7: Data cache write-back 64K, 2 ways
// RULE8: Data bypass on 15/1d, disabled, uncacheable
// RULE9: Level-2 write-back, bypassed when uncacheable
// RULE10: Level-2 state: valid, exclusive, modified bits
// RULE11: Level-1 states derived from level-2 state
// RULE12: Only 64-bit alternate opcodes, else fault 08
// RULE13: No translation on cache-control addresses
// RULE14: Low three address bits nonzero misaligned
// RULE15: Don't-care data reads zero, write ignored
// RULE16: Cache-control accesses always big-endian
// RULE17: Write to 67 flushes instruction cache
// RULE18: Error flag bit 24 sticky, write-1 clears
// RULE19: Bit 0 write flushes level-2, halts core
// RULE20: Write to 74 invalidates line partition-wide
// RULE21: Read of 74 raises invalid-space fault
// RULE22: Software sets weak ownership before 74 write
// RULE23: Faulting access has no side effect
`timescale 1ns/1ps
`default_nettype none
`include "chc_map.vh"
module chc_cache_hierarchy_control #(
   parameter L1_LINE_BYTES = `CHC_L1_LINE_BYTES,
   parameter L2_LINE_BYTES = `CHC_L2_LINE_BYTES,
   parameter L1_KBYTES     = `CHC_L1_KBYTES,
   parameter L1_WAYS       = `CHC_L1_WAYS,
   parameter [15:0] L2_FLUSH_CYCLES = `CHC_L2_FLUSH_CYCLES
) (
   // Clock and reset
   input  wire        clock,
   input  wire        rst_n,
   // Fetch bypass decision
   input  wire        fetch_req,
   input  wire        reset_recovery_state_flag,
   input  wire        instruction_cache_enable_control,
   input  wire        force_instruction_cacheable,
   input  wire        fetch_page_cacheable_physical,
   output reg         fetch_bypass_r,
   // Data bypass decision
   input  wire        data_req,
   input  wire [7:0]  data_space,
   input  wire        data_cache_enable_control,
   input  wire        data_page_cacheable_physical,
   output reg         data_bypass_r,
   output reg         level2_bypass_r,
   // Cache-control alternate-space access
   input  wire        ctl_req,
   input  wire        ctl_write,
   input  wire        ctl_opcode_ok,
   input  wire        ctl_supervisor,
   input  wire [7:0]  ctl_space,
   input  wire [63:0] ctl_addr,
   input  wire [63:0] ctl_wdata,
   output reg         ctl_ack_r,
   output reg  [63:0] ctl_rdata_r,
   output reg         ctl_space_fault_r,
   output reg         ctl_align_fault_r,
   output reg  [7:0]  data_fault_type_field_r,
   // Error events for sticky flag
   input  wire        err_event,
   // Cache maintenance actions
   output reg         l1i_flush_all_r,
   output reg         l2_flush_busy_r,
   output reg         halt_execution_r,
   output reg         line_inv_r,
   output reg  [63:0] line_inv_paddr_r,
   // Coherence state mapping
   input  wire [2:0]  l2_state,
   input  wire        l2_evict,
   input  wire        icode_store,
   output reg         l1d_valid_ok_r,
   output reg         l1d_mod_r,
   output reg         store_ownership_state_r,
   output reg         l1i_valid_ok_r,
   output reg         l1_evict_inv_r,
   output reg         l1i_line_inv_r
);
   // RULE1 RULE4 RULE7 RULE9: geometry fixed by parameters above
   localparam SUBLINES = L2_LINE_BYTES / L1_LINE_BYTES;

   // Level-2 line states; valid clear is invalid whatever the rest
   localparam [2:0] ST_SHARED_CLEAN = 3'b100;
   localparam [2:0] ST_EXCL_CLEAN   = 3'b110;
   localparam [2:0] ST_SHARED_MOD   = 3'b101;
   localparam [2:0] ST_EXCL_MOD     = 3'b111;
   // Whole level-2 flush sequencer states
   localparam       FL_IDLE         = 1'b0;
   localparam       FL_BUSY         = 1'b1;

   reg        sticky_error_trap_flag_r;
   reg        sticky_error_trap_flag_nxt;
   reg [15:0] flush_cnt_r;
   reg [15:0] flush_cnt_nxt;
   reg        flush_busy_nxt;
   reg        fetch_bypass_nxt;
   reg        data_bypass_nxt;
   reg        level2_bypass_nxt;
   reg        l1d_valid_ok_nxt;
   reg        l1d_mod_nxt;
   reg        store_ownership_state_nxt;
   reg        l1i_valid_ok_nxt;
   reg        space_known;
   reg        space_write_only;
   wire       addr_ok;
   wire       space_bad;
   wire       byp_space;
   wire       is_l1i;
   wire       is_l2c;
   wire       is_inv;
   wire       good;
   wire       err_clr;
   wire       flush_go;

   assign is_l1i = ctl_space == `CHC_SPACE_L1I_FLUSH;
   assign is_l2c = ctl_space == `CHC_SPACE_L2_CTRL;
   assign is_inv = ctl_space == `CHC_SPACE_LINE_INV;

   // Known spaces and those that refuse reads
   always @* begin
      space_known = 1'b0;
      space_write_only = 1'b0;
      case (ctl_space)
         `CHC_SPACE_L1I_FLUSH: begin
            space_known = 1'b1;
            space_write_only = 1'b1;
         end
         `CHC_SPACE_L2_CTRL: begin
            space_known = 1'b1;
         end
         `CHC_SPACE_LINE_INV: begin
            space_known = 1'b1;
            space_write_only = 1'b1;                    // RULE21
         end
         default: begin
            space_known = 1'b0;
            space_write_only = 1'b0;
         end
      endcase
   end

   // User access also faults as invalid space
   assign space_bad = ~ctl_opcode_ok | ~ctl_supervisor   // RULE12
                    | ~space_known
                    | (space_write_only & ~ctl_write);
   assign addr_ok = ctl_addr[2:0] == 3'b000;             // RULE14
   assign good = ctl_req & ~space_bad & addr_ok;         // RULE23
   assign err_clr = good & ctl_write & is_l2c
                  & ctl_wdata[`CHC_L2C_ERR_BIT];
   assign flush_go = good & ctl_write & is_l2c
                   & ctl_wdata[`CHC_L2C_FLUSH_BIT];      // RULE19

   assign byp_space = (data_space == `CHC_SPACE_BYP)
                    | (data_space == `CHC_SPACE_BYP_LE);

   // Bypass decisions, held between requests
   always @* begin
      fetch_bypass_nxt = fetch_bypass_r;
      data_bypass_nxt = data_bypass_r;
      level2_bypass_nxt = level2_bypass_r;
      if (fetch_req)
         fetch_bypass_nxt = ~force_instruction_cacheable  // RULE6
            & (reset_recovery_state_flag                  // RULE5
               | ~instruction_cache_enable_control
               | ~fetch_page_cacheable_physical);
      if (data_req) begin
         data_bypass_nxt = byp_space                      // RULE8
            | ~data_cache_enable_control
            | ~data_page_cacheable_physical;
         // Level-2 bypass ignores force-cacheable and enables
         level2_bypass_nxt = byp_space                    // RULE9
            | ~data_page_cacheable_physical;
      end
   end

   always @(posedge clock) begin
      if (!rst_n) begin
         fetch_bypass_r <= 1'b0;
         data_bypass_r <= 1'b0;
         level2_bypass_r <= 1'b0;
      end else begin
         fetch_bypass_r <= fetch_bypass_nxt;
         data_bypass_r <= data_bypass_nxt;
         level2_bypass_r <= level2_bypass_nxt;
      end
   end

   // Cache-control access answer, one cycle after request
   always @(posedge clock) begin
      if (!rst_n) begin
         ctl_ack_r <= 1'b0;
         ctl_rdata_r <= 64'h0000000000000000;
         ctl_space_fault_r <= 1'b0;
         ctl_align_fault_r <= 1'b0;
         data_fault_type_field_r <= 8'h00;
         l1i_flush_all_r <= 1'b0;
         line_inv_r <= 1'b0;
         line_inv_paddr_r <= 64'h0000000000000000;
      end else begin
         ctl_ack_r <= ctl_req;
         ctl_space_fault_r <= ctl_req & space_bad;
         ctl_align_fault_r <= ctl_req & ~space_bad & ~addr_ok;
         if (ctl_req & space_bad)
            data_fault_type_field_r <= `CHC_FT_BAD_SPACE;   // RULE12
         // Big-endian fixed; only flag bit visible, rest zero
         ctl_rdata_r <= 64'h0000000000000000;               // RULE15 RULE16
         if (good & ~ctl_write & is_l2c)
            ctl_rdata_r[`CHC_L2C_ERR_BIT] <= sticky_error_trap_flag_r;
         l1i_flush_all_r <= good & ctl_write & is_l1i;      // RULE17
         line_inv_r <= good & ctl_write & is_inv;           // RULE20
         // Address used untranslated, no masking
         if (good & ctl_write & is_inv)
            line_inv_paddr_r <= ctl_addr;                   // RULE13
      end
   end

   // Sticky flag: an error in the clearing cycle keeps it set
   always @* begin
      sticky_error_trap_flag_nxt = sticky_error_trap_flag_r;
      if (err_clr)
         sticky_error_trap_flag_nxt = 1'b0;
      if (err_event)
         sticky_error_trap_flag_nxt = 1'b1;                 // RULE18
   end

   // Flush request while busy is dropped
   always @* begin
      flush_busy_nxt = l2_flush_busy_r;
      flush_cnt_nxt = flush_cnt_r;
      case (l2_flush_busy_r)
         FL_IDLE: begin
            if (flush_go) begin
               flush_busy_nxt = FL_BUSY;                    // RULE19
               flush_cnt_nxt = L2_FLUSH_CYCLES;
            end
         end
         FL_BUSY: begin
            if (flush_cnt_r <= 16'h0001) begin
               flush_busy_nxt = FL_IDLE;
               flush_cnt_nxt = 16'h0000;
            end else begin
               flush_cnt_nxt = flush_cnt_r - 16'h0001;
            end
         end
         default: begin
            flush_busy_nxt = FL_IDLE;
            flush_cnt_nxt = 16'h0000;
         end
      endcase
   end

   always @(posedge clock) begin
      if (!rst_n) begin
         sticky_error_trap_flag_r <= 1'b0;
         flush_cnt_r <= 16'h0000;
         l2_flush_busy_r <= 1'b0;
         halt_execution_r <= 1'b0;
      end else begin
         sticky_error_trap_flag_r <= sticky_error_trap_flag_nxt;
         flush_cnt_r <= flush_cnt_nxt;
         l2_flush_busy_r <= flush_busy_nxt;
         // Core stays halted for the whole flush
         halt_execution_r <= flush_busy_nxt;                // RULE19
      end
   end

   // Level-1 and store-ownership view of the level-2 state
   always @* begin
      l1d_valid_ok_nxt = 1'b0;
      l1d_mod_nxt = 1'b0;
      store_ownership_state_nxt = 1'b0;
      l1i_valid_ok_nxt = 1'b0;
      case (l2_state)                               // RULE10 RULE11
         ST_SHARED_CLEAN, ST_EXCL_CLEAN, ST_SHARED_MOD: begin
            l1d_valid_ok_nxt = 1'b1;
            l1i_valid_ok_nxt = 1'b1;
         end
         ST_EXCL_MOD: begin
            l1d_valid_ok_nxt = 1'b1;
            l1d_mod_nxt = 1'b1;
            store_ownership_state_nxt = 1'b1;
         end
         default: begin
            l1d_valid_ok_nxt = 1'b0;
            l1i_valid_ok_nxt = 1'b0;
         end
      endcase
   end

   // Coherence mapping from level-2 state
   always @(posedge clock) begin
      if (!rst_n) begin
         l1d_valid_ok_r <= 1'b0;
         l1d_mod_r <= 1'b0;
         store_ownership_state_r <= 1'b0;
         l1i_valid_ok_r <= 1'b0;
         l1_evict_inv_r <= 1'b0;
         l1i_line_inv_r <= 1'b0;
      end else begin
         l1d_valid_ok_r <= l1d_valid_ok_nxt;
         l1d_mod_r <= l1d_mod_nxt;
         store_ownership_state_r <= store_ownership_state_nxt;
         l1i_valid_ok_r <= l1i_valid_ok_nxt;
         l1_evict_inv_r <= l2_evict;                        // RULE2
         l1i_line_inv_r <= icode_store;                     // RULE3
      end
   end
endmodule
`default_nettype wire

// *** hdl/chc_map.vh ***
`ifndef CHC_MAP_VH
`define CHC_MAP_VH
// Line geometry in bytes
`define CHC_L1_LINE_BYTES     64
`define CHC_L2_LINE_BYTES     256
`define CHC_L2_SUBLINES       4
// Level-1 sizes, level-2 maximum size and ways
`define CHC_L1_KBYTES         64
`define CHC_L1_WAYS           2
`define CHC_L2_MAX_MBYTE      6
`define CHC_L2_MAX_WAYS       12
// Address space codes
`define CHC_SPACE_BYP         8'h15
`define CHC_SPACE_BYP_LE      8'h1d
`define CHC_SPACE_L1I_FLUSH   8'h67
`define CHC_SPACE_L2_CTRL     8'h6a
`define CHC_SPACE_LINE_INV    8'h74
// Level-2 control register fields
`define CHC_L2C_ERR_BIT       24
`define CHC_L2C_FLUSH_BIT     0
`define CHC_L2C_RESET         64'h0000000000000000
// Fault type for invalid space
`define CHC_FT_BAD_SPACE      8'h08
// State encoding bits
`define CHC_ST_VALID          2
`define CHC_ST_EXCL           1
`define CHC_ST_MOD            0
// Default whole-level-2 flush duration in cycles
`define CHC_L2_FLUSH_CYCLES   16'h0100
`endif

// *** tb/cache_hierarchy_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module cache_hierarchy_control_tb;
   logic clock = 0, rst_n = 0, go = 0, flag = 0, fetch_req = 0, data_req = 0;
   logic err_event = 0, l2_evict = 0, icode_store = 0;
   logic reset_recovery_state_flag = 0, instruction_cache_enable_control = 0;
   logic force_instruction_cacheable = 0, fetch_page_cacheable_physical = 0;
   logic data_cache_enable_control = 0, data_page_cacheable_physical = 0;
   logic [2:0] l2_state = 0;
   logic [7:0] data_space = 0;
   logic [31:0] r = 0, seed = 32'h7a79e9d7, bad_count = 0, num_checks = 0;
   logic [31:0] cyc = 0, hcnt = 0;
   logic [63:0] a = 0, d = 0, pa = 0;
   logic [7:0] ft = 0;
   logic [148:0] e, got, q[$];
   wire ctl_req, ctl_write, ctl_opcode_ok, ctl_supervisor, ctl_ack_r;
   wire fetch_bypass_r, data_bypass_r, level2_bypass_r, ctl_space_fault_r;
   wire ctl_align_fault_r, l1i_flush_all_r, l2_flush_busy_r, halt_execution_r;
   wire line_inv_r, l1d_valid_ok_r, l1d_mod_r, store_ownership_state_r;
   wire l1i_valid_ok_r, l1_evict_inv_r, l1i_line_inv_r;
   wire [7:0] ctl_space, data_fault_type_field_r;
   wire [63:0] ctl_addr, ctl_wdata, ctl_rdata_r, line_inv_paddr_r;
   chc_cache_hierarchy_control #(.L2_FLUSH_CYCLES(16'h0004)) i_dut (.*);
   chc_core_model i_core (.*);
   always #50 clock = ~clock;
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task conclude();
      if (bad_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic xact(input logic [31:0] v, input logic [63:0] av, dv);
      logic sf, ok, wr;
      logic [7:0] s;
      go <= 1;
      {r, a, d} <= {v, av, dv};
      @(posedge clock);
      go <= 0;
      {fetch_req, data_req, err_event, l2_evict, icode_store} <=
         {2'h3, v[26] & v[25], v[24:23]};
      {reset_recovery_state_flag, instruction_cache_enable_control,
         force_instruction_cacheable, fetch_page_cacheable_physical,
         data_cache_enable_control, data_page_cacheable_physical,
         l2_state} <= {v[15:10], v[22:20]};
      data_space <= {3'h0, ~v[17], v[16], 3'h5};
      #1;
      s = ctl_space;
      wr = ctl_write;
      sf = !ctl_opcode_ok | !ctl_supervisor;
      sf = sf | !(s == 8'h6a | wr & (s == 8'h67 | s == 8'h74));
      ok = !sf & ~|ctl_addr[2:0];
      if (sf)
         ft = 8'h08;
      if (ok & wr & s == 8'h74)
         pa = ctl_addr;
      q.push_back({!v[13] & (v[15] | !v[14] | !v[12]),
         !v[17] | !v[11] | !v[10], !v[17] | !v[10],
         sf, !sf & !ok, ok & wr & s == 8'h67, ok & wr & s == 8'h74,
         v[22], v[22:20] == 3'h7, v[22:20] == 3'h7,
         v[22] & v[22:20] != 3'h7, v[24:23],
         ok & !wr & s == 8'h6a ? {39'h0, flag, 24'h0} : 64'h0, ft, pa});
      if (err_event)
         flag = 1;
      else if (ok & wr & s == 8'h6a & ctl_wdata[24])
         flag = 0;
      @(posedge clock);
      {fetch_req, data_req, err_event, l2_evict, icode_store} <= 5'h0;
      @(posedge clock);
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      hcnt <= hcnt + (halt_execution_r === 1'b1) + (l2_flush_busy_r === 1'b1);
      if (cyc == 2000) begin
         bad_count++;
         conclude();
      end
      if (ctl_ack_r === 1'b1) begin
         e = q.pop_front();
         got = {fetch_bypass_r, data_bypass_r, level2_bypass_r,
            ctl_space_fault_r, ctl_align_fault_r, l1i_flush_all_r, line_inv_r,
            l1d_valid_ok_r, l1d_mod_r, store_ownership_state_r,
            l1i_valid_ok_r, l1_evict_inv_r, l1i_line_inv_r, ctl_rdata_r,
            data_fault_type_field_r, line_inv_paddr_r};
         num_checks++;
         if (got !== e) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, e);
         end
      end
   end
   initial begin
      repeat (8) @(posedge clock);
      rst_n <= 1;
      for (int i = 0; i < 60; i++)
         xact(rnd(), {rnd(), rnd()}, {rnd(), rnd()} & ~64'h1);
      xact(32'h0600_002f, 0, 0);
      xact(32'h2f, 0, 0);
      xact(32'h3f, 0, 64'h100_0000);
      xact(32'h2f, 0, 0);
      xact(32'h3f, 0, 64'h1);
      repeat (12) @(posedge clock);
      num_checks++;
      if (hcnt !== 32'h8) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, hcnt, 32'h8);
      end
      conclude();
   end
endmodule
`default_nettype wire

// *** tb/chc_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module chc_core_model (
   // Command from the bench
   input  wire logic        clock, go,
   input  wire logic [31:0] r,
   input  wire logic [63:0] a, d,
   // Cache-control request toward the block
   output logic             ctl_req = 0, ctl_write = 0,
   output logic             ctl_opcode_ok = 0, ctl_supervisor = 0,
   output logic [7:0]       ctl_space = 0,
   output logic [63:0]      ctl_addr = 0, ctl_wdata = 0
);
   localparam [63:0] SPT = 64'h006a_1567_7474_6a67;
   logic weak_store_ownership_control = 1'b0;
   always @(posedge clock) begin
      // Set long before the first line-invalidation write
      weak_store_ownership_control <= 1'b1;
      ctl_req <= go;
      // Idle address and data invert every cycle
      ctl_addr <= go ? {a[63:3], a[2:0] & {3{r[8] & r[9]}}} : ~ctl_addr;
      ctl_wdata <= go ? d : ~ctl_wdata;
      if (go) begin
         {ctl_opcode_ok, ctl_supervisor} <= {|r[1:0], |r[3:2]};
         // No line-invalidation write without weak ownership
         ctl_write <= r[4] & (weak_store_ownership_control
            | SPT[8 * r[7:5] +: 8] != 8'h74);
         ctl_space <= SPT[8 * r[7:5] +: 8];
      end
   end
endmodule
`default_nettype wire

// *** tb/chc_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module chc_props (
   input wire logic        clock, rst_n, ctl_req, ctl_write, ctl_opcode_ok,
   input wire logic        ctl_supervisor, ctl_space_fault_r, ctl_align_fault_r,
   input wire logic        l1i_flush_all_r, halt_execution_r, line_inv_r,
   input wire logic        l2_evict, l1_evict_inv_r, store_ownership_state_r,
   input wire logic [7:0]  ctl_space, data_fault_type_field_r,
   input wire logic [63:0] ctl_addr, ctl_wdata,
   input wire logic [2:0]  l2_state
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire sp_ok = ctl_req & ctl_opcode_ok & ctl_supervisor & (ctl_space == 8'h6a
      | ctl_write & (ctl_space == 8'h67 | ctl_space == 8'h74));
   wire ok = sp_ok & ~|ctl_addr[2:0];
   a_space_fault: assert property (ctl_req & ~ctl_opcode_ok |=>
      ctl_space_fault_r && data_fault_type_field_r == 8'h08) else $error("opcode");
   a_misalign_fault: assert property (sp_ok & |ctl_addr[2:0] |=>
      ctl_align_fault_r && !line_inv_r && !l1i_flush_all_r) else $error("align");
   a_l1i_flush: assert property (ok & ctl_write & ctl_space == 8'h67 |=>
      l1i_flush_all_r) else $error("flush");
   a_line_inv: assert property (ok & ctl_write & ctl_space == 8'h74 |=>
      line_inv_r) else $error("inval");
   a_inv_read: assert property (ctl_req & ~ctl_write & ctl_space == 8'h74 |=>
      ctl_space_fault_r && !line_inv_r) else $error("read 74");
   a_l2_flush: assert property (ok & ctl_write & ctl_space == 8'h6a
      & ctl_wdata[0] |=> halt_execution_r) else $error("halt");
   a_evict_inv: assert property (l2_evict |=> l1_evict_inv_r)
      else $error("evict");
   a_owner_map: assert property (l2_state == 3'h7 |=> store_ownership_state_r
      ) else $error("owner");
   c_halt: cover property (halt_execution_r);
   c_align: cover property (ctl_align_fault_r);
   c_inval: cover property (line_inv_r);
endmodule
bind chc_cache_hierarchy_control chc_props i_props (.*);
`default_nettype wire
